// File: core/ext_irq_defines.svh
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_SENSE_CONTROL_LOW  8'h69
`define IDX_SENSE_CONTROL_HIGH 8'h6a
`define IDX_EXT_IRQ_MASK_REG   8'h1d
`define IDX_EXT_IRQ_FLAG_REG   8'h1c
`define IDX_PIN_CHANGE_CTRL    8'h68
`define IDX_PIN_CHANGE_FLAG    8'h1b
`define IDX_PIN_CHANGE_MASK0   8'h6b
`define IDX_PIN_CHANGE_MASK1   8'h6c
`define IDX_PIN_CHANGE_MASK2   8'h6d

// Reset values and field layout.
`define REG8_RESET             8'h00
`define PC_CTRL_RESET          3'h0
`define PC_FLAG_RESET          2'h0
`define SENSE_FIELD_W          2
`define EXT_ASYNC_EDGE_CNT     4
`define PC_GROUP0_CNT          8
`define PC_GROUP1_LINE         8
`define APB_DATA_W             32
`define REG_DATA_W             8
`define MIN_ADDR_W             10

`endif

// File: core/ext_irq_pkg.sv
package ext_irq_pkg;

  // Order gives the encodings 0 to 3 of a sense select field.
  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL,
    SENSE_ANY_EDGE,
    SENSE_FALLING_EDGE,
    SENSE_RISING_EDGE
  } sense_mode_t;

endpackage

// File: core/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // Pins from outside the clock domain.
  input  wire logic [WIDTH-1:0] async_in,
  // Filtered level in the clock domain.
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  // The first stage is read only by the second; a change counts once stages two and three agree.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r    <= '1;
      stage2_r  <= '1;
      stage3_r  <= '1;
      level_out <= '1;
    end else begin
      meta_r    <= async_in;
      stage2_r  <= meta_r;
      stage3_r  <= stage2_r;
      level_out <= (stage2_r & ~(stage2_r ^ stage3_r)) | (level_out & (stage2_r ^ stage3_r));
    end
  end

endmodule // pin_sync

// File: core/external_pin_interrupt_sense.sv
// The APB register port was chosen for this implementation.
`include "ext_irq_defines.svh"

module external_pin_interrupt_sense #(
  parameter int NUM_EXT = 8,
  parameter int NUM_PC  = 9,
  parameter int ADDR_W  = 12
) (
  // Clock and reset.
  input  wire logic                   core_clk_in,
  input  wire logic                   nrst_in,
  // APB slave.
  input  wire logic [ADDR_W-1:0]      paddr_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [`APB_DATA_W-1:0] pwdata_in,
  output logic      [`APB_DATA_W-1:0] prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  // Pins.
  input  wire logic [NUM_EXT-1:0]     ext_irq_pins_in,
  input  wire logic [NUM_PC-1:0]      pin_change_lines_in,
  // Core side.
  input  wire logic                   global_irq_enable_in,
  input  wire logic                   io_clk_run_in,
  input  wire logic [NUM_EXT-1:0]     ext_irq_ack_in,
  input  wire logic [1:0]             pc_irq_ack_in,
  output logic      [NUM_EXT-1:0]     ext_irq_req_out,
  output logic                        pin_change_group_zero_irq_out,
  output logic                        pin_change_group_one_irq_out,
  output logic                        wake_out
);

  // The register map is fixed at eight sources and nine pin-change lines.
  if (NUM_EXT != 8 || NUM_PC != 9) begin : g_bad_count
    $error("external_pin_interrupt_sense supports only 8 sources and 9 lines");
  end
  if (ADDR_W < `MIN_ADDR_W) begin : g_bad_addr
    $error("external_pin_interrupt_sense needs at least 10 address bits");
  end
  if (`EXT_ASYNC_EDGE_CNT >= NUM_EXT) begin : g_bad_split
    $error("external_pin_interrupt_sense needs sources above the clockless group");
  end

  logic [`REG_DATA_W-1:0] sense_control_low_r;
  logic [`REG_DATA_W-1:0] sense_control_high_r;
  logic [`REG_DATA_W-1:0] ext_irq_mask_r;
  logic [`REG_DATA_W-1:0] ext_irq_flag_r;
  logic [2:0]             pc_ctrl_r;
  logic [1:0]             pc_flag_r;
  logic [`REG_DATA_W-1:0] pc_mask0_r;
  logic                   pc_mask1_r;
  logic [`REG_DATA_W-1:0] pc_mask2_r;
  logic [NUM_EXT-1:0]     ext_prev_r;
  logic [NUM_PC-1:0]      pc_prev_r;
  logic [NUM_EXT-1:0]     ext_lvl;
  logic [NUM_PC-1:0]      pc_lvl;
  logic [NUM_EXT-1:0]     ext_trig;
  logic [NUM_EXT-1:0]     ext_is_level;
  logic [NUM_EXT-1:0]     ext_src;
  logic [NUM_PC-1:0]      pc_toggle;
  logic [1:0]             pc_trig;
  logic [`REG_DATA_W-1:0] rd_data;
  logic                   rd_mapped;
  logic                   setup_phase;
  logic                   wr_take;
  logic [`REG_DATA_W-1:0] wr_byte;
  logic [`REG_DATA_W-1:0] ext_clr;
  logic [1:0]             pc_clr;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    reg_hit = (addr == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic logic edge_hit(input ext_irq_pkg::sense_mode_t mode,
                                    input logic rise, input logic fall);
    unique case (mode)
      ext_irq_pkg::SENSE_LOW_LEVEL:    edge_hit = 1'b0;
      ext_irq_pkg::SENSE_ANY_EDGE:     edge_hit = rise | fall;
      ext_irq_pkg::SENSE_FALLING_EDGE: edge_hit = fall;
      ext_irq_pkg::SENSE_RISING_EDGE:  edge_hit = rise;
    endcase
  endfunction

  // Pins are sensed as they are, so a pin driven as output still triggers.
  // Pin capture runs through the synchroniser before any flag sees it.
  pin_sync #(
    .WIDTH (NUM_EXT)
  ) u_ext_sync (
    .clk_in    (core_clk_in),
    .nrst_in   (nrst_in),
    .async_in  (ext_irq_pins_in),
    .level_out (ext_lvl)
  );

  pin_sync #(
    .WIDTH (NUM_PC)
  ) u_pc_sync (
    .clk_in    (core_clk_in),
    .nrst_in   (nrst_in),
    .async_in  (pin_change_lines_in),
    .level_out (pc_lvl)
  );

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_prev_r <= '1;
      pc_prev_r  <= '1;
    end else begin
      ext_prev_r <= ext_lvl;
      pc_prev_r  <= pc_lvl;
    end
  end

  // Sense decode per source; fields sit two bits apart, source 0 lowest.
  always_comb begin
    logic [2*`REG_DATA_W-1:0] sense_all;
    ext_irq_pkg::sense_mode_t mode;
    sense_all = {sense_control_high_r, sense_control_low_r};
    mode      = ext_irq_pkg::SENSE_LOW_LEVEL;
    for (int i = 0; i < NUM_EXT; i++) begin
      mode = ext_irq_pkg::sense_mode_t'(
        sense_all[`SENSE_FIELD_W*i +: `SENSE_FIELD_W]);
      ext_is_level[i] = (mode == ext_irq_pkg::SENSE_LOW_LEVEL);
      ext_trig[i] = edge_hit(mode, ext_lvl[i] & ~ext_prev_r[i], ~ext_lvl[i] & ext_prev_r[i]);
      // Upper sources lose edges while the I/O clock is stopped; lower ones never do.
      if (i >= `EXT_ASYNC_EDGE_CNT) begin
        ext_trig[i] = ext_trig[i] & io_clk_run_in;
      end
      // The level source needs no edge, so it can wake the part from deep sleep.
      ext_src[i] = ext_is_level[i] ? ~ext_lvl[i] : ext_irq_flag_r[i];
    end
  end

  // Pin-change toggles, gated by the per-line masks.
  always_comb begin
    pc_toggle  = pc_lvl ^ pc_prev_r;
    pc_trig[0] = |(pc_toggle[`PC_GROUP0_CNT-1:0] & pc_mask0_r);
    pc_trig[1] = pc_toggle[`PC_GROUP1_LINE] & pc_mask1_r;
  end

  // Bus phases; the answer comes in the first access cycle.
  always_comb begin
    setup_phase = psel_in & ~penable_in;
    wr_take     = psel_in & penable_in & pready_out & pwrite_in;
    wr_byte     = pwdata_in[`REG_DATA_W-1:0];
  end

  always_comb begin
    ext_clr = ext_irq_ack_in;
    pc_clr  = pc_irq_ack_in;
    if (wr_take && reg_hit(paddr_in, `IDX_EXT_IRQ_FLAG_REG)) begin
      ext_clr = ext_clr | wr_byte;
    end
    if (wr_take && reg_hit(paddr_in, `IDX_PIN_CHANGE_FLAG)) begin
      pc_clr = pc_clr | wr_byte[1:0];
    end
  end

  always_comb begin
    rd_data   = `REG8_RESET;
    rd_mapped = 1'b1;
    if (reg_hit(paddr_in, `IDX_SENSE_CONTROL_LOW)) begin
      rd_data = sense_control_low_r;
    end else if (reg_hit(paddr_in, `IDX_SENSE_CONTROL_HIGH)) begin
      rd_data = sense_control_high_r;
    end else if (reg_hit(paddr_in, `IDX_EXT_IRQ_MASK_REG)) begin
      rd_data = ext_irq_mask_r;
    end else if (reg_hit(paddr_in, `IDX_EXT_IRQ_FLAG_REG)) begin
      rd_data = ext_irq_flag_r;
    end else if (reg_hit(paddr_in, `IDX_PIN_CHANGE_CTRL)) begin
      rd_data = {5'h00, pc_ctrl_r};
    end else if (reg_hit(paddr_in, `IDX_PIN_CHANGE_FLAG)) begin
      rd_data = {6'h00, pc_flag_r};
    end else if (reg_hit(paddr_in, `IDX_PIN_CHANGE_MASK0)) begin
      rd_data = pc_mask0_r;
    end else if (reg_hit(paddr_in, `IDX_PIN_CHANGE_MASK1)) begin
      rd_data = {7'h00, pc_mask1_r};
    end else if (reg_hit(paddr_in, `IDX_PIN_CHANGE_MASK2)) begin
      rd_data = pc_mask2_r;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // Bus answer registers.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else begin
      pready_out  <= setup_phase;
      pslverr_out <= setup_phase & ~rd_mapped;
      prdata_out  <= (setup_phase && !pwrite_in) ? {24'h000000, rd_data} : 32'h00000000;
    end
  end

  // Configuration registers. A sense change is not filtered, so masking first is on software.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sense_control_low_r  <= `REG8_RESET;
      sense_control_high_r <= `REG8_RESET;
      ext_irq_mask_r       <= `REG8_RESET;
      pc_ctrl_r            <= `PC_CTRL_RESET;
      pc_mask0_r           <= `REG8_RESET;
      pc_mask1_r           <= 1'b0;
      pc_mask2_r           <= `REG8_RESET;
    end else if (wr_take) begin
      if (reg_hit(paddr_in, `IDX_SENSE_CONTROL_LOW)) begin
        sense_control_low_r <= wr_byte;
      end
      if (reg_hit(paddr_in, `IDX_SENSE_CONTROL_HIGH)) begin
        sense_control_high_r <= wr_byte;
      end
      if (reg_hit(paddr_in, `IDX_EXT_IRQ_MASK_REG)) begin
        ext_irq_mask_r <= wr_byte;
      end
      if (reg_hit(paddr_in, `IDX_PIN_CHANGE_CTRL)) begin
        pc_ctrl_r <= wr_byte[2:0];
      end
      if (reg_hit(paddr_in, `IDX_PIN_CHANGE_MASK0)) begin
        pc_mask0_r <= wr_byte;
      end
      if (reg_hit(paddr_in, `IDX_PIN_CHANGE_MASK1)) begin
        pc_mask1_r <= wr_byte[0];
      end
      // Stored for software only; the third group has no lines behind it.
      if (reg_hit(paddr_in, `IDX_PIN_CHANGE_MASK2)) begin
        pc_mask2_r <= wr_byte;
      end
    end
  end

  // External flags: a trigger in the clearing cycle wins; level mode holds them clear.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_irq_flag_r <= `REG8_RESET;
    end else begin
      ext_irq_flag_r <= ((ext_irq_flag_r & ~ext_clr) | ext_trig)
        & ~ext_is_level;
    end
  end

  // Pin-change flags, same set-over-clear order.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_flag_r <= `PC_FLAG_RESET;
    end else begin
      pc_flag_r <= (pc_flag_r & ~pc_clr) | pc_trig;
    end
  end

  // Requests to the core. A level request drops as soon as the pin rises again.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_irq_req_out               <= '0;
      pin_change_group_zero_irq_out <= 1'b0;
      pin_change_group_one_irq_out  <= 1'b0;
    end else begin
      ext_irq_req_out[`EXT_ASYNC_EDGE_CNT-1:0] <=
        ext_src[`EXT_ASYNC_EDGE_CNT-1:0] & ext_irq_mask_r[`EXT_ASYNC_EDGE_CNT-1:0]
        & {`EXT_ASYNC_EDGE_CNT{global_irq_enable_in}};
      ext_irq_req_out[NUM_EXT-1:`EXT_ASYNC_EDGE_CNT] <=
        ext_src[NUM_EXT-1:`EXT_ASYNC_EDGE_CNT] & ext_irq_mask_r[NUM_EXT-1:`EXT_ASYNC_EDGE_CNT]
        & {(NUM_EXT-`EXT_ASYNC_EDGE_CNT){global_irq_enable_in}};
      pin_change_group_zero_irq_out <=
        pc_flag_r[0] & pc_ctrl_r[0] & global_irq_enable_in;
      pin_change_group_one_irq_out  <=
        pc_flag_r[1] & pc_ctrl_r[1] & global_irq_enable_in;
    end
  end

  // Wake-up ignores the global enable, since sleep is often entered with it clear.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= (|(ext_src & ext_irq_mask_r))
        | (|(pc_flag_r & pc_ctrl_r[1:0]));
    end
  end

endmodule // external_pin_interrupt_sense

// File: tb/ext_irq_properties.sv
module ext_irq_properties #(
  parameter int NUM_EXT = 8
) (
  input wire logic               core_clk_in,
  input wire logic               nrst_in,
  input wire logic               psel_in,
  input wire logic               penable_in,
  input wire logic               global_irq_enable_in,
  input wire logic [31:0]        prdata_out,
  input wire logic               pready_out,
  input wire logic               pslverr_out,
  input wire logic [NUM_EXT-1:0] ext_irq_req_out,
  input wire logic               pin_change_group_zero_irq_out,
  input wire logic               pin_change_group_one_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_read_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  a_read_upper_zero: assert property (prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  a_gie_blocks_low: assert property (
    !global_irq_enable_in |=> ext_irq_req_out[3:0] == 4'h0)
    else $error("low request without global enable");
  a_gie_blocks_high: assert property (
    !global_irq_enable_in |=> ext_irq_req_out[NUM_EXT-1:4] == '0)
    else $error("high request without global enable");
  a_gie_blocks_pc: assert property (
    !global_irq_enable_in |=> !pin_change_group_zero_irq_out && !pin_change_group_one_irq_out)
    else $error("group request without global enable");
endmodule // ext_irq_properties

bind external_pin_interrupt_sense ext_irq_properties #(.NUM_EXT(NUM_EXT)) u_props (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
  .global_irq_enable_in(global_irq_enable_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .ext_irq_req_out(ext_irq_req_out),
  .pin_change_group_zero_irq_out(pin_change_group_zero_irq_out),
  .pin_change_group_one_irq_out(pin_change_group_one_irq_out));

// File: tb/pin_source_model.sv
module pin_source_model (
  input wire logic       core_clk_in,
  input wire logic [7:0] ext_lvl_in,
  input wire logic [8:0] pc_lvl_in,
  output logic     [7:0] ext_irq_pins_out,
  output logic     [8:0] pin_change_lines_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins idle high, as pulled up.
  initial begin
    ext_irq_pins_out = 8'hff;
    pin_change_lines_out = 9'h1ff;
  end
  // A level is held for many cycles until commanded off, so it outlasts wake-up.
  always @(posedge core_clk_in) begin
    ext_irq_pins_out <= ext_lvl_in;
    pin_change_lines_out <= pc_lvl_in;
  end
endmodule // pin_source_model

// File: tb/tb_top.sv
`include "ext_irq_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_in, nrst_in, psel, penable, pwrite, gie, io_run;
  logic        pready, pslverr, pc0, pc1, last_err, wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  ext_lvl, pins, ext_ack, req, seed;
  logic [8:0]  pc_lvl, lines;
  logic [1:0]  pc_ack;
  logic [15:0] sense;
  int          num_errors, tests_run, s, m, k;

  external_pin_interrupt_sense u_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .ext_irq_pins_in(pins), .pin_change_lines_in(lines), .global_irq_enable_in(gie),
    .io_clk_run_in(io_run), .ext_irq_ack_in(ext_ack), .pc_irq_ack_in(pc_ack),
    .ext_irq_req_out(req), .pin_change_group_zero_irq_out(pc0),
    .pin_change_group_one_irq_out(pc1), .wake_out(wake));
  pin_source_model u_src (.core_clk_in(core_clk_in), .ext_lvl_in(ext_lvl), .pc_lvl_in(pc_lvl),
    .ext_irq_pins_out(pins), .pin_change_lines_out(lines));

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  // Bus cycles wait for ready; only the watchdog ends a wait that never closes.
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge core_clk_in);
    paddr <= 12'(idx) << 2;
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_sense;
    apb(`IDX_SENSE_CONTROL_LOW, 1'b1, {24'h0, sense[7:0]});
    apb(`IDX_SENSE_CONTROL_HIGH, 1'b1, {24'h0, sense[15:8]});
  endtask

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100us;
    num_errors++;
    $display("Watchdog expired");
    print_verdict;
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    gie = 1'b0;
    io_run = 1'b1;
    ext_lvl = 8'hff;
    pc_lvl = 9'h1ff;
    ext_ack = 8'h00;
    pc_ack = 2'h0;
    nrst_in = 1'b0;
    seed = 8'h4b;
    num_errors = 0;
    tests_run = 0;
    cyc(5);
    nrst_in <= 1'b1;
    apb(`IDX_SENSE_CONTROL_LOW, 1'b0, 0);
    chk(rd, 0);
    apb(`IDX_SENSE_CONTROL_HIGH, 1'b0, 0);
    chk(rd, 0);
    apb(8'h20, 1'b0, 0);
    chk({31'h0, last_err}, 1);
    seed = lfsr(seed);
    sense[7:0] = seed;
    seed = lfsr(seed);
    sense[15:8] = seed;
    wr_sense;
    apb(`IDX_SENSE_CONTROL_LOW, 1'b0, 0);
    chk(rd, {24'h0, sense[7:0]});
    apb(`IDX_SENSE_CONTROL_HIGH, 1'b0, 0);
    chk(rd, {24'h0, sense[15:8]});
    chk({31'h0, wake}, 0);
    $display("Test registers done");
    gie <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      s = i % 8;
      m = (i + i / 8) % 4;
      apb(`IDX_EXT_IRQ_MASK_REG, 1'b1, 0);
      sense[2*s +: 2] = m[1:0];
      wr_sense;
      apb(`IDX_EXT_IRQ_FLAG_REG, 1'b1, 32'hff);
      apb(`IDX_EXT_IRQ_MASK_REG, 1'b1, 32'h1 << s);
      ext_lvl[s] <= 1'b0;
      cyc(8);
      chk({24'h0, req}, (m != 3) ? 32'h1 << s : 0);
      apb(`IDX_EXT_IRQ_FLAG_REG, 1'b0, 0);
      chk(rd, (m == 1 || m == 2) ? 32'h1 << s : 0);
      if (s % 2 == 0) begin
        ext_ack <= 8'h1 << s;
        cyc(1);
        ext_ack <= 8'h0;
      end else begin
        apb(`IDX_EXT_IRQ_FLAG_REG, 1'b1, 32'h1 << s);
      end
      ext_lvl[s] <= 1'b1;
      cyc(8);
      chk({24'h0, req}, (m == 1 || m == 3) ? 32'h1 << s : 0);
    end
    $display("Test sense modes done");
    apb(`IDX_EXT_IRQ_MASK_REG, 1'b1, 0);
    sense = 16'haaaa;
    wr_sense;
    apb(`IDX_EXT_IRQ_FLAG_REG, 1'b1, 32'hff);
    apb(`IDX_EXT_IRQ_MASK_REG, 1'b1, 32'h11);
    io_run <= 1'b0;
    ext_lvl <= 8'hee;
    cyc(8);
    chk({24'h0, req}, 32'h1);
    chk({31'h0, wake}, 1);
    ext_lvl <= 8'hff;
    io_run <= 1'b1;
    apb(`IDX_EXT_IRQ_MASK_REG, 1'b1, 0);
    $display("Test clock gating done");
    seed = lfsr(seed);
    k = seed[2:0];
    apb(`IDX_PIN_CHANGE_CTRL, 1'b1, 32'h3);
    apb(`IDX_PIN_CHANGE_MASK0, 1'b1, 32'h1 << k);
    apb(`IDX_PIN_CHANGE_MASK1, 1'b1, 32'h1);
    apb(`IDX_PIN_CHANGE_MASK2, 1'b1, 32'hff);
    apb(`IDX_PIN_CHANGE_MASK2, 1'b0, 0);
    chk(rd, 32'hff);
    pc_lvl[(k + 1) % 8] <= 1'b0;
    cyc(8);
    chk({30'h0, pc1, pc0}, 0);
    pc_lvl[k] <= 1'b0;
    cyc(8);
    chk({30'h0, pc1, pc0}, 1);
    pc_ack <= 2'h1;
    cyc(1);
    pc_ack <= 2'h0;
    cyc(2);
    chk({30'h0, pc1, pc0}, 0);
    gie <= 1'b0;
    pc_lvl[8] <= 1'b0;
    cyc(8);
    chk({30'h0, pc1, pc0}, 0);
    chk({31'h0, wake}, 1);
    gie <= 1'b1;
    cyc(2);
    chk({30'h0, pc1, pc0}, 2);
    $display("Test pin change done");
    nrst_in <= 1'b0;
    cyc(2);
    nrst_in <= 1'b1;
    chk({21'h0, wake, pc1, pc0, req}, 0);
    apb(`IDX_SENSE_CONTROL_LOW, 1'b0, 0);
    chk(rd, 0);
    apb(`IDX_PIN_CHANGE_MASK2, 1'b0, 0);
    chk(rd, 0);
    $display("Test reset done");
    print_verdict;
  end
endmodule // tb_top
